// file: inc/dpcb_defs.vh
`ifndef DPCB_DEFS_VH
`define DPCB_DEFS_VH

// ****************************************************************
// parameter select codes
// ****************************************************************
`define DPCB_SEL_MAIN_SUPPLY 3'h0
`define DPCB_SEL_DISPLAY 3'h1
`define DPCB_SEL_COMM_SPEC 3'h2
`define DPCB_SEL_STATION 3'h3
`define DPCB_SEL_ADJ_ONE 3'h4
`define DPCB_SEL_ADJ_TWO 3'h5
`define DPCB_SEL_ADJ_THREE 3'h6
`define DPCB_SEL_ADJ_FOUR 3'h7

// ****************************************************************
// digit positions (low bit of each nibble)
// ****************************************************************
`define DPCB_DIG_SHOW_ALL 0
`define DPCB_DIG_PHASE 8
`define DPCB_DIG_DC_INPUT 8
`define DPCB_DIG_SPEED 0
`define DPCB_DIG_FRAME 4
`define DPCB_DIG_ADDR_SRC 0

// ****************************************************************
// factory values
// ****************************************************************
`define DPCB_RST_MAIN_SUPPLY 16'h0000
`define DPCB_RST_DISPLAY 16'h0000
`define DPCB_RST_COMM_SPEC_V0 16'h0011
`define DPCB_RST_COMM_SPEC_V1 16'h0010
`define DPCB_RST_COMM_SPEC_V2 16'h0000
`define DPCB_RST_STATION_V0 16'h0001
`define DPCB_RST_STATION_V1 16'h0021
`define DPCB_RST_STATION_V2 16'h0001
`define DPCB_RST_ADJ 16'h0000
`define DPCB_STATION_MAX_NARROW 16'h00ff

// ****************************************************************
// network variants and decoded frame lengths
// ****************************************************************
`define DPCB_VAR_FIRST 2'h0
`define DPCB_VAR_SECOND 2'h1
`define DPCB_VAR_ETHER 2'h2
`define DPCB_FRAME_17 6'h11
`define DPCB_FRAME_32 6'h20
`define DPCB_FRAME_48 6'h30

`endif

// file: rtl/dpcb_digit_filter.v
`timescale 1ns/10ps
`default_nettype none

// keeps the stored digit when the new one is not a defined choice
module dpcb_digit_filter
(
    input wire [3:0] old_digit, // digit now stored
    input wire [3:0] new_digit, // digit being written
    output wire [3:0] next_digit // digit to store
);

    // only 0 and 1 are defined for selection digits
    assign next_digit = (new_digit <= 4'h1) ? new_digit : old_digit;

endmodule // dpcb_digit_filter

`default_nettype wire

// file: rtl/dpcb_bank.v
`timescale 1ns/10ps
`default_nettype none
`include "dpcb_defs.vh"

module dpcb_bank
#(
    parameter [1:0] NET_VARIANT = 2'h0 // 0 first fieldbus, 1 second, 2 ethernet
)
(
    input wire core_clk, // 10 mhz system clock
    input wire rst, // power-up reset, async, active high
    input wire par_wr, // one-cycle write strobe
    input wire par_src_host, // 1 write from host software, 0 from panel
    input wire [2:0] par_sel, // parameter select
    input wire [15:0] par_wdata, // write data
    input wire write_inhibit, // panel write inhibit setting
    input wire servo_on, // drive is in servo on
    input wire init_req, // one-cycle initialization request
    input wire [15:0] sii_station_word, // info area word at 0004h
    input wire dc_supply_pin, // sensed main supply is dc, async pin
    output reg [15:0] par_rdata, // stored value of selected parameter
    output reg wr_ack, // write taken
    output reg wr_reject, // write refused
    output reg init_done, // initialization carried out
    output reg init_reject, // initialization refused
    output reg show_all, // panel shows all parameters
    output reg link_10m, // link rate 10 mbit/s, else 4
    output reg [5:0] frame_len, // transfer frame length in bytes
    output reg [15:0] station_addr, // active station address
    output reg dc_input, // dc main input selected
    output reg single_phase, // single-phase ac input selected
    output reg regen_en, // internal regeneration processing on
    output reg wiring_alarm // main circuit wiring alarm
);

    // ****************************************************************
    // factory values for this variant
    // ****************************************************************
    localparam [15:0] RST_COMM = (NET_VARIANT == `DPCB_VAR_FIRST) ? `DPCB_RST_COMM_SPEC_V0 :
                                 (NET_VARIANT == `DPCB_VAR_SECOND) ? `DPCB_RST_COMM_SPEC_V1 :
                                 `DPCB_RST_COMM_SPEC_V2;
    localparam [15:0] RST_STATION = (NET_VARIANT == `DPCB_VAR_FIRST) ? `DPCB_RST_STATION_V0 :
                                    (NET_VARIANT == `DPCB_VAR_SECOND) ? `DPCB_RST_STATION_V1 :
                                    `DPCB_RST_STATION_V2;

    // ****************************************************************
    // parameter store
    // ****************************************************************
    reg [15:0] main_supply_mode_select;
    reg [15:0] display_and_phase_select;
    reg [15:0] network_comm_spec;
    reg [15:0] network_station_number;
    reg [15:0] adjust_utility_one;
    reg [15:0] adjust_utility_two;
    reg [15:0] adjust_utility_three;
    reg [15:0] adjust_utility_four;
    reg active_loaded;
    reg dc_sync_a;
    reg dc_sync_b;

    wire [3:0] next_show_dig;
    wire [3:0] next_phase_dig;
    wire [3:0] next_dc_dig;
    wire [3:0] next_speed_dig;
    wire [3:0] next_frame_dig;

    // ****************************************************************
    // selection digit filters
    // ****************************************************************
    dpcb_digit_filter u_show
    (
        .old_digit(display_and_phase_select[`DPCB_DIG_SHOW_ALL +: 4]),
        .new_digit(par_wdata[`DPCB_DIG_SHOW_ALL +: 4]),
        .next_digit(next_show_dig)
    );

    dpcb_digit_filter u_phase
    (
        .old_digit(display_and_phase_select[`DPCB_DIG_PHASE +: 4]),
        .new_digit(par_wdata[`DPCB_DIG_PHASE +: 4]),
        .next_digit(next_phase_dig)
    );

    dpcb_digit_filter u_dc
    (
        .old_digit(main_supply_mode_select[`DPCB_DIG_DC_INPUT +: 4]),
        .new_digit(par_wdata[`DPCB_DIG_DC_INPUT +: 4]),
        .next_digit(next_dc_dig)
    );

    dpcb_digit_filter u_speed
    (
        .old_digit(network_comm_spec[`DPCB_DIG_SPEED +: 4]),
        .new_digit(par_wdata[`DPCB_DIG_SPEED +: 4]),
        .next_digit(next_speed_dig)
    );

    dpcb_digit_filter u_frame
    (
        .old_digit(network_comm_spec[`DPCB_DIG_FRAME +: 4]),
        .new_digit(par_wdata[`DPCB_DIG_FRAME +: 4]),
        .next_digit(next_frame_dig)
    );

    // ****************************************************************
    // write and initialization qualification
    // ****************************************************************
    wire panel_blocked = write_inhibit & ~par_src_host;
    wire station_bad = (NET_VARIANT != `DPCB_VAR_ETHER) &&
                       (par_wdata > `DPCB_STATION_MAX_NARROW);
    wire wr_refused = panel_blocked | ((par_sel == `DPCB_SEL_STATION) & station_bad);
    wire wr_go = par_wr & ~wr_refused;
    wire init_ok = ~write_inhibit & ~servo_on;
    wire init_go = init_req & init_ok;

    // ****************************************************************
    // store update
    // ****************************************************************
    // init takes priority over a write landing in the same cycle
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            main_supply_mode_select <= `DPCB_RST_MAIN_SUPPLY;
            display_and_phase_select <= `DPCB_RST_DISPLAY;
            network_comm_spec <= RST_COMM;
            network_station_number <= RST_STATION;
            adjust_utility_one <= `DPCB_RST_ADJ;
            adjust_utility_two <= `DPCB_RST_ADJ;
            adjust_utility_three <= `DPCB_RST_ADJ;
            adjust_utility_four <= `DPCB_RST_ADJ;
        end
        else if (init_go)
        begin
            // adjustment results deliberately left alone
            main_supply_mode_select <= `DPCB_RST_MAIN_SUPPLY;
            display_and_phase_select <= `DPCB_RST_DISPLAY;
            network_comm_spec <= RST_COMM;
            network_station_number <= RST_STATION;
        end
        else if (wr_go)
        begin
            case (par_sel)
                `DPCB_SEL_MAIN_SUPPLY:
                begin
                    main_supply_mode_select <= {par_wdata[15:12], next_dc_dig,
                                                par_wdata[7:0]};
                end
                `DPCB_SEL_DISPLAY:
                begin
                    display_and_phase_select <= {par_wdata[15:12], next_phase_dig,
                                                 par_wdata[7:4], next_show_dig};
                end
                `DPCB_SEL_COMM_SPEC:
                begin
                    network_comm_spec <= {par_wdata[15:8], next_frame_dig,
                                          next_speed_dig};
                end
                `DPCB_SEL_STATION:
                begin
                    network_station_number <= par_wdata;
                end
                `DPCB_SEL_ADJ_ONE:
                begin
                    adjust_utility_one <= par_wdata;
                end
                `DPCB_SEL_ADJ_TWO:
                begin
                    adjust_utility_two <= par_wdata;
                end
                `DPCB_SEL_ADJ_THREE:
                begin
                    adjust_utility_three <= par_wdata;
                end
                default:
                begin
                    adjust_utility_four <= par_wdata;
                end
            endcase
        end
    end

    // ****************************************************************
    // handshake outputs and read data
    // ****************************************************************
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ack <= 1'b0;
            wr_reject <= 1'b0;
            init_done <= 1'b0;
            init_reject <= 1'b0;
            par_rdata <= 16'h0000;
        end
        else
        begin
            // a write lost to a same-cycle init is reported as refused
            wr_ack <= wr_go & ~init_go;
            wr_reject <= par_wr & (wr_refused | init_go);
            init_done <= init_go;
            init_reject <= init_req & ~init_ok;
            case (par_sel)
                `DPCB_SEL_MAIN_SUPPLY: par_rdata <= main_supply_mode_select;
                `DPCB_SEL_DISPLAY: par_rdata <= display_and_phase_select;
                `DPCB_SEL_COMM_SPEC: par_rdata <= network_comm_spec;
                `DPCB_SEL_STATION: par_rdata <= network_station_number;
                `DPCB_SEL_ADJ_ONE: par_rdata <= adjust_utility_one;
                `DPCB_SEL_ADJ_TWO: par_rdata <= adjust_utility_two;
                `DPCB_SEL_ADJ_THREE: par_rdata <= adjust_utility_three;
                default: par_rdata <= adjust_utility_four;
            endcase
        end
    end

    // ****************************************************************
    // supply sense synchroniser
    // ****************************************************************
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dc_sync_a <= 1'b0;
            dc_sync_b <= 1'b0;
        end
        else
        begin
            dc_sync_a <= dc_supply_pin;
            dc_sync_b <= dc_sync_a;
        end
    end

    // ****************************************************************
    // decode of stored digits
    // ****************************************************************
    reg [5:0] dec_frame;
    reg dec_speed;
    reg [15:0] dec_station;

    always @*
    begin
        dec_speed = 1'b0;
        dec_station = network_station_number;
        dec_frame = `DPCB_FRAME_32;
        case (NET_VARIANT)
            `DPCB_VAR_FIRST:
            begin
                dec_speed = network_comm_spec[`DPCB_DIG_SPEED];
                dec_frame = network_comm_spec[`DPCB_DIG_FRAME] ?
                            `DPCB_FRAME_32 : `DPCB_FRAME_17;
            end
            `DPCB_VAR_SECOND:
            begin
                dec_frame = network_comm_spec[`DPCB_DIG_FRAME] ?
                            `DPCB_FRAME_48 : `DPCB_FRAME_32;
            end
            default:
            begin
                if (network_comm_spec[`DPCB_DIG_ADDR_SRC])
                begin
                    dec_station = sii_station_word;
                end
            end
        endcase
    end

    // ****************************************************************
    // active controls, loaded once after power-up
    // ****************************************************************
    // the store only reaches these here, so later writes and inits
    // never reach them; a power cycle also returns the store to factory
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            active_loaded <= 1'b0;
            show_all <= 1'b0;
            link_10m <= 1'b0;
            frame_len <= `DPCB_FRAME_32;
            station_addr <= 16'h0000;
            dc_input <= 1'b0;
            single_phase <= 1'b0;
            regen_en <= 1'b0;
        end
        else if (!active_loaded)
        begin
            active_loaded <= 1'b1;
            show_all <= display_and_phase_select[`DPCB_DIG_SHOW_ALL];
            link_10m <= dec_speed;
            frame_len <= dec_frame;
            station_addr <= dec_station;
            dc_input <= main_supply_mode_select[`DPCB_DIG_DC_INPUT];
            single_phase <= display_and_phase_select[`DPCB_DIG_PHASE];
            regen_en <= ~main_supply_mode_select[`DPCB_DIG_DC_INPUT];
        end
    end

    // ****************************************************************
    // wiring alarm
    // ****************************************************************
    // held off until the selection is active so a stale store cannot trip it
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wiring_alarm <= 1'b0;
        end
        else
        begin
            wiring_alarm <= active_loaded & (dc_input != dc_sync_b);
        end
    end

endmodule // dpcb_bank

`default_nettype wire

// file: sim/dpcb_props.sv
`timescale 1ns/10ps
`default_nettype none

module dpcb_props
#(
    parameter [1:0] NET_VARIANT = 2'h0 // network variant of the bound bank
)
(
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset
    input wire logic par_wr, // write strobe
    input wire logic par_src_host, // host or panel
    input wire logic [2:0] par_sel, // parameter select
    input wire logic [15:0] par_wdata, // write data
    input wire logic write_inhibit, // panel inhibit
    input wire logic servo_on, // servo on state
    input wire logic init_req, // init request
    input wire logic [15:0] sii_station_word, // info word
    input wire logic dc_supply_pin, // sensed supply
    input wire logic [15:0] par_rdata, // read data
    input wire logic wr_ack, // write taken
    input wire logic wr_reject, // write refused
    input wire logic init_done, // init done
    input wire logic init_reject, // init refused
    input wire logic show_all, // panel view
    input wire logic link_10m, // link rate
    input wire logic [5:0] frame_len, // frame bytes
    input wire logic [15:0] station_addr, // station
    input wire logic dc_input, // dc selected
    input wire logic single_phase, // single phase
    input wire logic regen_en, // regeneration on
    input wire logic wiring_alarm // wiring alarm
);
    // ****************************************************************
    // cycles since release, saturating; controls settle after edge one
    // ****************************************************************
    logic [1:0] up_cnt;
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            up_cnt <= 2'h0;
        else if (up_cnt != 2'h3)
            up_cnt <= up_cnt + 2'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ****************************************************************
    // properties
    // ****************************************************************
    sequence s_adj_write;
        par_wr && par_src_host && par_sel[2] && !init_req ##1 wr_ack && $stable(par_sel);
    endsequence
    sequence s_init_adj;
        init_req && !write_inhibit && !servo_on && par_sel[2] && $stable(par_sel)
        ##1 $stable(par_sel) && !par_wr;
    endsequence
    property p_panel_inhibit;
        par_wr && write_inhibit && !par_src_host |=> wr_reject && !wr_ack;
    endproperty
    property p_host_write;
        par_wr && par_src_host && !init_req && par_sel != 3'h3 |=> wr_ack && !wr_reject;
    endproperty
    property p_station_range;
        par_wr && par_sel == 3'h3 && par_wdata > 16'h00ff && NET_VARIANT != 2'h2 |=> wr_reject;
    endproperty
    property p_init_go;
        init_req && !write_inhibit && !servo_on |=> init_done && !init_reject;
    endproperty
    property p_init_refuse;
        init_req && (write_inhibit || servo_on) |=> init_reject && !init_done;
    endproperty
    property p_adj_readback;
        s_adj_write |=> par_rdata == $past(par_wdata, 2);
    endproperty
    property p_init_keeps_adj;
        s_init_adj |=> $stable(par_rdata);
    endproperty
    property p_active_hold;
        up_cnt == 2'h3 |-> $stable(show_all) && $stable(link_10m) && $stable(frame_len)
            && $stable(station_addr) && $stable(dc_input) && $stable(single_phase);
    endproperty
    property p_regen;
        up_cnt != 2'h0 |-> regen_en == !dc_input;
    endproperty
    property p_frame;
        up_cnt != 2'h0 && NET_VARIANT == 2'h0 |-> frame_len == 6'h11 || frame_len == 6'h20;
    endproperty
    property p_station_active;
        up_cnt != 2'h0 && NET_VARIANT != 2'h2 |-> station_addr <= 16'h00ff;
    endproperty
    property p_alarm;
        (up_cnt == 2'h3 && $stable(dc_supply_pin))[*4] |-> wiring_alarm == (dc_input ^ dc_supply_pin);
    endproperty
    a_panel_inhibit : assert property (p_panel_inhibit) else $error("panel write not refused");
    a_host_write : assert property (p_host_write) else $error("host write not taken");
    a_station_range : assert property (p_station_range) else $error("station out of range taken");
    a_init_go : assert property (p_init_go) else $error("init not done");
    a_init_refuse : assert property (p_init_refuse) else $error("init not refused");
    a_adj_readback : assert property (p_adj_readback) else $error("stored word differs");
    a_init_keeps_adj : assert property (p_init_keeps_adj) else $error("adjust value lost");
    a_active_hold : assert property (p_active_hold) else $error("active control moved");
    a_regen : assert property (p_regen) else $error("regeneration wrong");
    a_frame : assert property (p_frame) else $error("frame length illegal");
    a_station_active : assert property (p_station_active) else $error("station too large");
    a_alarm : assert property (p_alarm) else $error("wiring alarm wrong");
endmodule // dpcb_props
`default_nettype wire

// file: sim/dpcb_supply_model.sv
`timescale 1ns/10ps
`default_nettype none

// supply and drive state as seen by the bank; moves only off the sampling edge
module dpcb_supply_model
#(
    parameter [15:0] INFO_WORD = 16'h0042 // arbitrary info area content
)
(
    input wire logic core_clk, // system clock
    input wire logic want_dc, // apply dc supply
    input wire logic want_servo, // request servo on
    output var logic dc_supply_pin, // sensed dc supply
    output var logic servo_on, // servo on state
    output var logic [15:0] sii_station_word // info area word
);
    initial
    begin
        dc_supply_pin = 1'b0;
        servo_on = 1'b0;
    end
    always @(negedge core_clk)
    begin
        dc_supply_pin <= want_dc;
        servo_on <= want_servo;
    end
    assign sii_station_word = INFO_WORD;
endmodule // dpcb_supply_model
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpcb_defs.vh"

module testbench;
    logic core_clk, rst, par_wr, par_src_host, write_inhibit, init_req, want_dc, want_servo;
    logic [2:0] par_sel;
    logic [15:0] par_wdata, sii_station_word, par_rdata, station_addr;
    logic dc_supply_pin, servo_on, wr_ack, wr_reject, init_done, init_reject, show_all;
    logic link_10m, dc_input, single_phase, regen_en, wiring_alarm;
    logic [5:0] frame_len;
    logic [15:0] fact [0:7] = '{`DPCB_RST_MAIN_SUPPLY, `DPCB_RST_DISPLAY,
        `DPCB_RST_COMM_SPEC_V0, `DPCB_RST_STATION_V0, `DPCB_RST_ADJ, `DPCB_RST_ADJ,
        `DPCB_RST_ADJ, `DPCB_RST_ADJ};
    int fail_count = 0;
    int n_compared = 0;

    dpcb_bank #(.NET_VARIANT(`DPCB_VAR_FIRST)) uut (.core_clk(core_clk), .rst(rst),
        .par_wr(par_wr), .par_src_host(par_src_host), .par_sel(par_sel),
        .par_wdata(par_wdata), .write_inhibit(write_inhibit), .servo_on(servo_on),
        .init_req(init_req), .sii_station_word(sii_station_word),
        .dc_supply_pin(dc_supply_pin), .par_rdata(par_rdata), .wr_ack(wr_ack),
        .wr_reject(wr_reject), .init_done(init_done), .init_reject(init_reject),
        .show_all(show_all), .link_10m(link_10m), .frame_len(frame_len),
        .station_addr(station_addr), .dc_input(dc_input), .single_phase(single_phase),
        .regen_en(regen_en), .wiring_alarm(wiring_alarm));
    dpcb_supply_model u_supply (.core_clk(core_clk), .want_dc(want_dc),
        .want_servo(want_servo), .dc_supply_pin(dc_supply_pin), .servo_on(servo_on),
        .sii_station_word(sii_station_word));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ****************************************************************
    // access tasks
    // ****************************************************************
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic host, input logic [2:0] sel, input logic [15:0] data, input logic ok);
        @(negedge core_clk);
        par_wr = 1'b1;
        par_src_host = host;
        par_sel = sel;
        par_wdata = data;
        @(negedge core_clk);
        par_wr = 1'b0;
        chk("wr_ack", wr_ack, ok);
        chk("wr_reject", wr_reject, !ok);
    endtask
    task rd(input logic [2:0] sel, input logic [15:0] exp);
        @(negedge core_clk);
        par_sel = sel;
        @(negedge core_clk);
        chk("par_rdata", par_rdata, exp);
    endtask
    task init(input logic ok);
        @(negedge core_clk);
        init_req = 1'b1;
        @(negedge core_clk);
        init_req = 1'b0;
        chk("init_done", init_done, ok);
        chk("init_reject", init_reject, !ok);
    endtask
    // factory decode of the first variant; never moves until power cycle
    task chk_out;
        chk("show_all", show_all, 1'b0);
        chk("link_10m", link_10m, 1'b1);
        chk("frame_len", frame_len, `DPCB_FRAME_32);
        chk("station_addr", station_addr, `DPCB_RST_STATION_V0);
        chk("dc_input", dc_input, 1'b0);
        chk("single_phase", single_phase, 1'b0);
        chk("regen_en", regen_en, 1'b1);
    endtask
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        rst = 1'b1;
        {par_wr, write_inhibit, init_req, want_dc, want_servo} = 5'h00;
        par_src_host = 1'b1;
        par_sel = 3'h0;
        par_wdata = 16'h0000;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk_out();
        chk("wiring_alarm", wiring_alarm, 1'b0);
        for (int i = 0; i < 8; i++)
            rd(3'(i), fact[i]);
        wr(1'b1, `DPCB_SEL_DISPLAY, 16'h0101, 1'b1);
        wr(1'b1, `DPCB_SEL_MAIN_SUPPLY, 16'h0100, 1'b1);
        wr(1'b1, `DPCB_SEL_COMM_SPEC, 16'h0000, 1'b1);
        wr(1'b1, `DPCB_SEL_STATION, 16'h0100, 1'b0);
        wr(1'b1, `DPCB_SEL_STATION, 16'h00ff, 1'b1);
        rd(`DPCB_SEL_STATION, 16'h00ff);
        // undefined digit values must leave the old digit in place
        wr(1'b1, `DPCB_SEL_COMM_SPEC, 16'h5a23, 1'b1);
        rd(`DPCB_SEL_COMM_SPEC, 16'h5a00);
        wr(1'b1, `DPCB_SEL_DISPLAY, 16'h0f25, 1'b1);
        rd(`DPCB_SEL_DISPLAY, 16'h0121);
        rd(`DPCB_SEL_MAIN_SUPPLY, 16'h0100);
        chk_out();
        write_inhibit = 1'b1;
        wr(1'b0, `DPCB_SEL_ADJ_ONE, 16'h1234, 1'b0);
        rd(`DPCB_SEL_ADJ_ONE, `DPCB_RST_ADJ);
        wr(1'b1, `DPCB_SEL_ADJ_ONE, 16'h5a5a, 1'b1);
        init(1'b0);
        write_inhibit = 1'b0;
        want_servo = 1'b1;
        repeat (2) @(negedge core_clk);
        init(1'b0);
        want_servo = 1'b0;
        rd(`DPCB_SEL_ADJ_ONE, 16'h5a5a);
        init(1'b1);
        for (int i = 0; i < 4; i++)
            rd(3'(i), fact[i]);
        rd(`DPCB_SEL_ADJ_ONE, 16'h5a5a);
        chk_out();
        want_dc = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("wiring_alarm", wiring_alarm, 1'b1);
        want_dc = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("wiring_alarm", wiring_alarm, 1'b0);
        // power cycle in mid-run: store and controls come back to factory
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        rd(`DPCB_SEL_ADJ_ONE, `DPCB_RST_ADJ);
        chk_out();
        chk("wiring_alarm", wiring_alarm, 1'b0);
        close_out();
    end
    initial
    begin
        repeat (2000) @(posedge core_clk);
        fail_count++;
        close_out();
    end
endmodule // testbench

bind dpcb_bank dpcb_props #(.NET_VARIANT(NET_VARIANT)) u_props (.core_clk(core_clk), .rst(rst),
    .par_wr(par_wr), .par_src_host(par_src_host), .par_sel(par_sel), .par_wdata(par_wdata),
    .write_inhibit(write_inhibit), .servo_on(servo_on), .init_req(init_req),
    .sii_station_word(sii_station_word), .dc_supply_pin(dc_supply_pin),
    .par_rdata(par_rdata), .wr_ack(wr_ack), .wr_reject(wr_reject), .init_done(init_done),
    .init_reject(init_reject), .show_all(show_all), .link_10m(link_10m),
    .frame_len(frame_len), .station_addr(station_addr), .dc_input(dc_input),
    .single_phase(single_phase), .regen_en(regen_en), .wiring_alarm(wiring_alarm));
`default_nettype wire
